// *** pdc_pkg.sv ***
// constants and types for the synthesizer divider and oscillator calibration block
// Operation
// - feedback divider correct for either prescaler without changing integer or fraction
// - device derives swallow and main counts itself, not host visible
// - calibration starts as soon as enable is written to one, unless bypass is set
// - calibration picks oscillator and trim matching tuning level, accuracy selectable
// - calibration clock is detector rate scaled by select field, 0.1 to 1 MHz
// - counter overflow during calibration sets a sticky error flag
// - automatic choice within 17 calibration cycles, trim only within 13
// - calibration results read only through readback, not manual fields
// - bypass uses written oscillator and trim fields directly
// - after calibration the loop returns to the phase detector
// - outputs disabled after power-up until host enables them
// - external oscillator enable powers buffer, replaces internal ones, loop stays active
// - readback bit 12 carries calibration overflow flag
// - readback bits 20..15 trim and 23..22 oscillator outside test mode
package pdc_pkg;
	localparam logic [4:0] OFS_DIV = 5'h00;
	localparam logic [4:0] OFS_FRAC = 5'h04;
	localparam logic [4:0] OFS_CTRL = 5'h08;
	localparam logic [4:0] OFS_MANUAL = 5'h0c;
	localparam logic [4:0] OFS_FRACCFG = 5'h10;
	localparam logic [4:0] OFS_CMD = 5'h14;
	localparam logic [4:0] OFS_READBACK = 5'h18;
	localparam logic [4:0] OFS_STATUS = 5'h1c;
	// div register: reference divider [12:0], integer value [31:16]
	localparam int REF_LSB = 0;
	localparam int INT_LSB = 16;
	// ctrl register fields
	localparam int CTL_TXDIV = 0;
	localparam int CTL_PLLDIV = 2;
	localparam int CTL_PRSC = 4;
	localparam int CTL_CALCLK = 5;
	localparam int CTL_ACC = 9;
	localparam int CTL_CALREF = 10;
	localparam int CTL_OSCMODE = 13;
	localparam int CTL_EXTOSC = 14;
	localparam int CTL_EXTNEG = 15;
	localparam int CTL_BYPASS = 16;
	localparam int CTL_TEST = 17;
	localparam int CTL_CNTSEL = 18;
	localparam int CTL_RFEN = 19;
	localparam int CTL_LOEN = 20;
	localparam int CTL_W = 21;
	// manual register: trim [5:0], oscillator [9:8]
	localparam int MAN_OSC = 8;
	// fraccfg register fields
	localparam int FC_OFSEN = 0;
	localparam int FC_DITH = 1;
	localparam int FC_ORD = 2;
	localparam int FC_DSEL = 4;
	localparam int FC_DEL = 5;
	localparam int FC_LOCKOFS = 7;
	localparam int FC_POL = 8;
	localparam int FC_W = 9;
	// readback fields
	localparam int RB_OVF = 12;
	localparam int RB_CNT = 13;
	localparam int RB_TRIM = 15;
	localparam int RB_OSC = 22;
	localparam int RB_CNTSEL = 31;
	localparam logic [CTL_W-1:0] CTL_RST = 21'h000000;
	localparam logic [9:0] MAN_RST = 10'h020;
	localparam logic [FC_W-1:0] FC_RST = 9'h000;
	localparam logic [31:0] DIV_RST = 32'h00500001;
	localparam logic [17:0] CNT_MAX = 18'h3ffff;
	localparam logic [17:0] CAL_CNT_LIMIT = 18'h003ff;
	localparam logic [7:0] PRSC_HI_NUM = 8'h08;
	localparam logic [7:0] PRSC_LO_NUM = 8'h04;
	localparam logic [2:0] IDX_AUTO = 3'h7;
	localparam logic [2:0] IDX_MANUAL = 3'h5;
	typedef enum logic [1:0] {
		PDC_IDLE = 2'b00,
		PDC_TRY = 2'b01,
		PDC_SETTLE = 2'b10,
		PDC_DONE = 2'b11
	} pdc_cal_st_t;
endpackage

// *** pdc_tick_if.sv ***
// calibration clock tick link between the register block and the scaler
`timescale 1ns/1ps
interface pdc_tick_if;
	logic pfd_tick;
	logic [3:0] scale_sel;
	logic cal_tick;
	modport scaler (input pfd_tick, input scale_sel, output cal_tick);
	modport user (output pfd_tick, output scale_sel, input cal_tick);
endinterface

// *** pdc_cal_clk.sv ***
// calibration clock scaler: detector ticks scaled by the select field
`timescale 1ns/1ps
module pdc_cal_clk
	import pdc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	pdc_tick_if.scaler tk
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic [7:0] limit;
	logic tick_ff;
	logic wrap;
	// sel 0..7 divides by 1,2,4..128; bit 3 is ignored, so sel 8..15 divide the same as sel 0..7
	assign limit = (8'h01 << tk.scale_sel[2:0]) - 8'h01;
	assign wrap = (cnt_ff >= limit);
	assign nxt_cnt = wrap ? 8'h00 : cnt_ff + 8'h01;
	assign tk.cal_tick = tick_ff;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_ff <= 8'h00;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= 1'b0;
			if (tk.pfd_tick) begin
				cnt_ff <= nxt_cnt;
				tick_ff <= wrap;
			end
		end
	end
endmodule

// *** pdc_top.sv ***
// divider configuration and oscillator calibration engine with register port
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module pdc_top
	import pdc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic pfd_tick_i,
	input wire logic fn_tick_i,
	input wire logic tune_above_ref_i,
	output logic [12:0] reference_divider_o,
	output logic [15:0] feedback_integer_value_o,
	output logic [24:0] feedback_fraction_word_o,
	output logic prescaler_ratio_select_o,
	output logic [1:0] tx_div_sel_o,
	output logic [1:0] pll_div_sel_o,
	output logic [12:0] main_count_o,
	output logic [2:0] swallow_count_o,
	output logic [2:0] cal_ref_level_o,
	output logic [1:0] vco_select_o,
	output logic [5:0] cap_trim_o,
	output logic cal_mode_o,
	output logic vco_force_o,
	output logic vco_force_low_o,
	output logic ext_buffer_power_o,
	output logic int_vco_power_o,
	output logic external_gain_polarity_o,
	output logic loop_active_o,
	output logic rf_out_enable_o,
	output logic lo_out_enable_o,
	output logic [FC_W-1:0] frac_cfg_o
);
	logic [31:0] div_ff;
	logic [24:0] frac_ff;
	logic [CTL_W-1:0] ctl_ff;
	logic [9:0] man_ff;
	logic [FC_W-1:0] fc_ff;
	logic [31:0] rdata_ff;
	pdc_cal_st_t st_ff;
	pdc_cal_st_t nxt_st;
	logic [7:0] trial_ff;
	logic [2:0] idx_ff;
	logic settle_ff;
	logic ovf_ff;
	logic done_ff;
	logic [17:0] cnt_ff;
	logic [17:0] cnt_snap_ff;
	logic [1:0] res_vco_ff;
	logic [5:0] res_trim_ff;
	pdc_tick_if tk ();

	pdc_cal_clk u_cal_clk (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.tk(tk)
	);

	// register decode
	wire wr_div = reg_wr_i && (reg_addr_i == OFS_DIV);
	wire wr_frac = reg_wr_i && (reg_addr_i == OFS_FRAC);
	wire wr_ctl = reg_wr_i && (reg_addr_i == OFS_CTRL);
	wire wr_man = reg_wr_i && (reg_addr_i == OFS_MANUAL);
	wire wr_fc = reg_wr_i && (reg_addr_i == OFS_FRACCFG);
	wire cal_req = reg_wr_i && (reg_addr_i == OFS_CMD) && reg_wdata_i[0];
	wire cal_tick = tk.cal_tick;
	wire busy = (st_ff != PDC_IDLE) && (st_ff != PDC_DONE);
	wire bypass = ctl_ff[CTL_BYPASS];
	wire test_mode = ctl_ff[CTL_TEST];
	wire auto_osc = !ctl_ff[CTL_OSCMODE];
	wire long_settle = ctl_ff[CTL_ACC];
	// a calibration request while bypassed is ignored
	wire cal_start = cal_req && !bypass;
	wire [2:0] start_idx = auto_osc ? IDX_AUTO : IDX_MANUAL;
	wire [7:0] start_trial = auto_osc ? 8'h80 : {man_ff[MAN_OSC+1:MAN_OSC], 6'h20};
	wire [7:0] bit_mask = 8'h01 << idx_ff;
	wire [7:0] next_mask = 8'h01 << (idx_ff - 3'h1);
	wire decide = (st_ff == PDC_SETTLE) && cal_tick && (settle_ff || !long_settle);
	wire last_bit = (idx_ff == 3'h0);
	// keep the trial bit while the tuning level still sits above the reference
	wire [7:0] kept = tune_above_ref_i ? trial_ff : (trial_ff & ~bit_mask);
	wire cnt_sat = (cnt_ff == CNT_MAX);
	wire cal_ovf = busy && (cnt_ff >= CAL_CNT_LIMIT);

	// swallow and main counts follow the prescaler numerator
	wire [15:0] feedback_integer_value = div_ff[INT_LSB+15:INT_LSB];
	wire prsc_hi = ctl_ff[CTL_PRSC];
	// 4/5 is only used below 56, so the dropped top quotient bit is zero there
	assign main_count_o = prsc_hi ? feedback_integer_value[15:3] : feedback_integer_value[14:2];
	assign swallow_count_o = prsc_hi ? feedback_integer_value[2:0] : {1'b0, feedback_integer_value[1:0]};

	assign tk.pfd_tick = pfd_tick_i;
	assign tk.scale_sel = ctl_ff[CTL_CALCLK+3:CTL_CALCLK];

	// readback word
	wire [31:0] rb_cal = ({30'h0, res_vco_ff} << RB_OSC) | ({26'h0, res_trim_ff} << RB_TRIM);
	wire [31:0] rb_test = ({14'h0, cnt_snap_ff} << RB_CNT) | ({31'h0, ctl_ff[CTL_CNTSEL]} << RB_CNTSEL);
	wire [31:0] rb_word = (test_mode ? rb_test : rb_cal) | ({31'h0, ovf_ff} << RB_OVF);
	wire [31:0] status_word = {29'h0, ovf_ff, done_ff, busy};
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr_i)
			OFS_DIV: rd_mux = div_ff;
			OFS_FRAC: rd_mux = {7'h0, frac_ff};
			OFS_CTRL: rd_mux = {11'h0, ctl_ff};
			OFS_MANUAL: rd_mux = {22'h0, man_ff};
			OFS_FRACCFG: rd_mux = {23'h0, fc_ff};
			OFS_READBACK: rd_mux = rb_word;
			OFS_STATUS: rd_mux = status_word;
			default: rd_mux = 32'h0;
		endcase
	end

	// configuration registers
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			div_ff <= DIV_RST;
			frac_ff <= 25'h0;
			ctl_ff <= CTL_RST;
			man_ff <= MAN_RST;
			fc_ff <= FC_RST;
			rdata_ff <= 32'h0;
		end else begin
			if (wr_div) begin
				div_ff <= {reg_wdata_i[31:16], 3'h0, reg_wdata_i[12:0]};
			end
			if (wr_frac) begin
				frac_ff <= reg_wdata_i[24:0];
			end
			if (wr_ctl) begin
				ctl_ff <= reg_wdata_i[CTL_W-1:0];
			end
			if (wr_man) begin
				man_ff <= {reg_wdata_i[9:8], 2'h0, reg_wdata_i[5:0]};
			end
			if (wr_fc) begin
				fc_ff <= reg_wdata_i[FC_W-1:0];
			end
			rdata_ff <= reg_rd_i ? rd_mux : 32'h0;
		end
	end

	// calibration sequencer
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			PDC_IDLE, PDC_DONE: begin
				if (cal_start) begin
					nxt_st = PDC_TRY;
				end
			end
			PDC_TRY: begin
				if (cal_tick) begin
					nxt_st = PDC_SETTLE;
				end
			end
			PDC_SETTLE: begin
				if (decide) begin
					nxt_st = last_bit ? PDC_DONE : PDC_SETTLE;
				end
			end
			default: nxt_st = PDC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_ff <= PDC_IDLE;
			trial_ff <= 8'h0;
			idx_ff <= 3'h0;
			settle_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (cal_start && !busy) begin
				trial_ff <= start_trial;
				idx_ff <= start_idx;
				settle_ff <= 1'b0;
			end else if (st_ff == PDC_SETTLE && cal_tick) begin
				settle_ff <= !decide;
				if (decide) begin
					trial_ff <= last_bit ? kept : (kept | next_mask);
					idx_ff <= last_bit ? idx_ff : idx_ff - 3'h1;
				end
			end
		end
	end

	// results, done and overflow flags
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			res_vco_ff <= 2'h0;
			res_trim_ff <= 6'h0;
			done_ff <= 1'b0;
			ovf_ff <= 1'b0;
		end else begin
			if (decide && last_bit) begin
				res_vco_ff <= kept[7:6];
				res_trim_ff <= kept[5:0];
			end
			if (decide && last_bit) begin
				done_ff <= 1'b1;
			end else if (cal_start) begin
				done_ff <= 1'b0;
			end
			// a fresh overflow beats the clear at start
			if (cal_ovf) begin
				ovf_ff <= 1'b1;
			end else if (cal_start && !busy) begin
				ovf_ff <= 1'b0;
			end
		end
	end

	// divider cycle counter per calibration clock period
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_ff <= 18'h0;
			cnt_snap_ff <= 18'h0;
		end else if (cal_tick) begin
			cnt_snap_ff <= cnt_ff;
			cnt_ff <= 18'h0;
		end else if (fn_tick_i && !cnt_sat) begin
			cnt_ff <= cnt_ff + 18'h1;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign reference_divider_o = div_ff[REF_LSB+12:REF_LSB];
	assign feedback_integer_value_o = feedback_integer_value;
	assign feedback_fraction_word_o = frac_ff;
	assign prescaler_ratio_select_o = prsc_hi;
	assign tx_div_sel_o = ctl_ff[CTL_TXDIV+1:CTL_TXDIV];
	assign pll_div_sel_o = ctl_ff[CTL_PLLDIV+1:CTL_PLLDIV];
	assign cal_ref_level_o = ctl_ff[CTL_CALREF+2:CTL_CALREF];
	assign frac_cfg_o = fc_ff;
	// bypass drives the written fields; otherwise trial while busy, result after
	assign vco_select_o = bypass ? man_ff[MAN_OSC+1:MAN_OSC] : (busy ? trial_ff[7:6] : res_vco_ff);
	assign cap_trim_o = bypass ? man_ff[5:0] : (busy ? trial_ff[5:0] : res_trim_ff);
	assign cal_mode_o = busy;
	assign loop_active_o = !busy;
	assign vco_force_o = test_mode;
	assign vco_force_low_o = ctl_ff[CTL_CNTSEL];
	assign ext_buffer_power_o = ctl_ff[CTL_EXTOSC];
	assign int_vco_power_o = !ctl_ff[CTL_EXTOSC];
	assign external_gain_polarity_o = ctl_ff[CTL_EXTNEG];
	assign rf_out_enable_o = ctl_ff[CTL_RFEN];
	assign lo_out_enable_o = ctl_ff[CTL_LOEN];
endmodule

// *** pdc_top_assertions.sv ***
// concurrent checks on the divider and calibration block ports
`timescale 1ns/1ps
module pdc_chk
	import pdc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic pfd_tick_i,
	input wire logic [15:0] feedback_integer_value_o,
	input wire logic prescaler_ratio_select_o,
	input wire logic [12:0] main_count_o,
	input wire logic [2:0] swallow_count_o,
	input wire logic [1:0] vco_select_o,
	input wire logic [5:0] cap_trim_o,
	input wire logic cal_mode_o,
	input wire logic ext_buffer_power_o,
	input wire logic int_vco_power_o,
	input wire logic loop_active_o,
	input wire logic rf_out_enable_o,
	input wire logic lo_out_enable_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic [CTL_W-1:0] ctl_ff;
	logic [9:0] man_ff;
	logic [15:0] tk_ff;
	logic [15:0] lim;
	wire cw = reg_wr_i && reg_addr_i == OFS_CTRL;
	wire mw = reg_wr_i && reg_addr_i == OFS_MANUAL;
	// detector ticks allowed while busy, one spare calibration period for phase
	assign lim = 16'((2 + (ctl_ff[CTL_OSCMODE] ? 6 : 8) * (ctl_ff[CTL_ACC] ? 2 : 1)) << ctl_ff[CTL_CALCLK+:3]);
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ctl_ff <= CTL_RST;
			man_ff <= MAN_RST;
			tk_ff <= '0;
		end else begin
			if (cw) ctl_ff <= reg_wdata_i[CTL_W-1:0];
			if (mw) man_ff <= reg_wdata_i[9:0];
			tk_ff <= cal_mode_o ? tk_ff + 16'(pfd_tick_i) : 16'h0000;
		end
	end
	a_cal_start: assert property (
		reg_wr_i && reg_addr_i == OFS_CMD && reg_wdata_i[0] && !ctl_ff[CTL_BYPASS] |=> cal_mode_o)
		else $error("calibration did not start");
	a_loop_back: assert property (loop_active_o == !cal_mode_o)
		else $error("loop not handed back");
	a_cal_bound: assert property (tk_ff <= lim)
		else $error("calibration too long");
	a_out_off: assert property (disable iff (1'b0) rst_i |=> !rf_out_enable_o && !lo_out_enable_o)
		else $error("outputs on after reset");
	a_bypass_use: assert property (
		ctl_ff[CTL_BYPASS] && !cal_mode_o |-> vco_select_o == man_ff[9:8] && cap_trim_o == man_ff[5:0])
		else $error("bypass fields not used");
	a_ext_swap: assert property (ext_buffer_power_o != int_vco_power_o)
		else $error("oscillator routing wrong");
	a_split_hi: assert property (prescaler_ratio_select_o |->
		main_count_o == feedback_integer_value_o[15:3] && swallow_count_o == feedback_integer_value_o[2:0])
		else $error("8/9 counts wrong");
	a_split_lo: assert property (!prescaler_ratio_select_o |->
		main_count_o == 13'(feedback_integer_value_o[15:2]) && swallow_count_o == {1'b0, feedback_integer_value_o[1:0]})
		else $error("4/5 counts wrong");
	a_result_hold: assert property (
		!cal_mode_o && !$past(cal_mode_o) && !$past(cal_mode_o, 2) && !ctl_ff[CTL_BYPASS]
		&& !$past(ctl_ff[CTL_BYPASS]) |-> $stable(vco_select_o) && $stable(cap_trim_o))
		else $error("result changed while idle");
	c_cal_end: cover property ($fell(cal_mode_o));
	c_ovf_read: cover property (reg_rdata_o[RB_OVF]);
	c_byp_start: cover property (ctl_ff[CTL_BYPASS] && reg_wr_i && reg_addr_i == OFS_CMD);
endmodule

// *** pdc_loop_model.sv ***
// analog loop stand-in: detector and feedback ticks and the tuning comparator
`timescale 1ns/1ps
module pdc_loop_model (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [1:0] vco_select_i,
	input wire logic [5:0] cap_trim_i,
	input wire logic [7:0] target_i,
	input wire logic fast_i,
	output logic pfd_tick_o,
	output logic fn_tick_o,
	output logic tune_above_ref_o
);
	logic [7:0] cnt_ff;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			cnt_ff <= '0;
		else
			cnt_ff <= cnt_ff + 8'h01;
	end
	// detector every 16 clocks; fast feedback overruns the slowest calibration period
	assign pfd_tick_o = cnt_ff[3:0] == 4'h0;
	assign fn_tick_o = fast_i || cnt_ff[2:0] == 3'h0;
	assign tune_above_ref_o = {vco_select_i, cap_trim_i} <= target_i;
endmodule

// *** pdc_top_bench.sv ***
// self-checking bench for the divider and calibration block
`timescale 1ns/1ps
module pdc_top_bench
	import pdc_pkg::*;
;
	logic clk_sys_i = 0;
	logic rst_i = 1;
	logic [4:0] reg_addr_i = '0;
	logic [31:0] reg_wdata_i = '0;
	logic reg_wr_i = 0;
	logic reg_rd_i = 0;
	logic fast = 0;
	logic [7:0] target = '0;
	logic [31:0] reg_rdata_o, rd_v;
	logic pfd_tick_i, fn_tick_i, tune_above_ref_i, prescaler_ratio_select_o, cal_mode_o, loop_active_o;
	logic ext_buffer_power_o, int_vco_power_o, rf_out_enable_o, lo_out_enable_o;
	logic [15:0] feedback_integer_value_o;
	logic [24:0] feedback_fraction_word_o;
	logic [12:0] main_count_o;
	logic [2:0] swallow_count_o;
	logic [1:0] vco_select_o;
	logic [5:0] cap_trim_o;
	logic [FC_W-1:0] frac_cfg_o;
	logic [12:0] reference_divider_o;
	logic [1:0] tx_div_sel_o, pll_div_sel_o;
	logic [2:0] cal_ref_level_o;
	logic vco_force_o, vco_force_low_o, external_gain_polarity_o;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	logic [4:0] ra[6] = '{OFS_DIV, OFS_MANUAL, OFS_CTRL, OFS_FRACCFG, OFS_STATUS, 5'h02};
	logic [31:0] rv[6] = '{DIV_RST, 32'(MAN_RST), 0, 0, 0, 0};
	logic [15:0] nv[4] = '{16'h0038, 16'h003d, 16'h000c, 16'h0320};
	pdc_top DUT (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.pfd_tick_i, .fn_tick_i, .tune_above_ref_i, .reference_divider_o, .feedback_integer_value_o,
		.feedback_fraction_word_o, .prescaler_ratio_select_o, .tx_div_sel_o, .pll_div_sel_o,
		.main_count_o, .swallow_count_o, .cal_ref_level_o, .vco_select_o, .cap_trim_o, .cal_mode_o,
		.vco_force_o, .vco_force_low_o, .ext_buffer_power_o, .int_vco_power_o,
		.external_gain_polarity_o, .loop_active_o, .rf_out_enable_o, .lo_out_enable_o, .frac_cfg_o);
	pdc_loop_model u_loop (.clk_sys_i, .rst_i, .vco_select_i(vco_select_o), .cap_trim_i(cap_trim_o),
		.target_i(target), .fast_i(fast), .pfd_tick_o(pfd_tick_i), .fn_tick_o(fn_tick_i),
		.tune_above_ref_o(tune_above_ref_i));
	always #5 clk_sys_i = ~clk_sys_i;
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		rd_v = reg_rdata_o;
	endtask
	// bound b in clocks; loop stays inactive while calibrating
	task automatic cal_case(input logic [31:0] c, input logic [7:0] t, input int b, input logic o);
		int n;
		n = 0;
		target = t;
		wr(OFS_CTRL, c);
		wr(OFS_CMD, 32'h1);
		chk(32'({cal_mode_o, loop_active_o}), 2);
		while (cal_mode_o !== 1'b0 && n < b + 4) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		chk(32'(n <= b), 1);
		chk(32'({loop_active_o, vco_select_o, cap_trim_o}), {1'b1, t});
		rd(OFS_READBACK);
		chk(rd_v & 32'h00df9000, (32'(t[7:6]) << RB_OSC) | (32'(t[5:0]) << RB_TRIM) | (32'(o) << RB_OVF));
		rd(OFS_STATUS);
		chk(rd_v & 32'h7, {o, 2'b10});
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1;
		chk(32'({rf_out_enable_o, lo_out_enable_o}), 0);
		foreach (ra[i]) begin
			rd(ra[i]);
			chk(rd_v, rv[i]);
		end
		wr(OFS_FRAC, 32'd75);
		foreach (nv[i])
			for (int p = 0; p < 2; p++) begin
				wr(OFS_DIV, {nv[i], 16'h0014});
				wr(OFS_CTRL, 32'(p) << CTL_PRSC);
				chk({feedback_integer_value_o, main_count_o, swallow_count_o},
					{nv[i], 13'(nv[i] >> (p ? 3 : 2)), 3'(p ? nv[i] % 8 : nv[i] % 4)});
				chk(32'({feedback_fraction_word_o, prescaler_ratio_select_o}), {25'd75, p[0]});
			end
		chk(32'(reference_divider_o), 32'h14);
		wr(OFS_FRACCFG, 32'hfffffecb);
		rd(OFS_FRACCFG);
		chk(rd_v, 32'h000000cb);
		chk(32'(frac_cfg_o), 32'h000000cb);
		wr(OFS_CTRL, (32'h1 << CTL_TXDIV) | (32'h1 << CTL_PLLDIV) | (32'h4 << CTL_CALREF) | (32'h3 << CTL_EXTOSC)
			| (32'h3 << CTL_RFEN));
		chk(32'({tx_div_sel_o, pll_div_sel_o, cal_ref_level_o, external_gain_polarity_o, ext_buffer_power_o,
			int_vco_power_o, loop_active_o, rf_out_enable_o, lo_out_enable_o}), 32'h0b37);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1;
		chk(32'({rf_out_enable_o, lo_out_enable_o}), 0);
		cal_case(32'h0, 8'ha5, 160, 1'b0);
		wr(OFS_MANUAL, 32'h00000215);
		cal_case((32'h1 << CTL_OSCMODE) | (32'h1 << CTL_ACC), 8'h9b, 224, 1'b0);
		rd(OFS_MANUAL);
		chk(rd_v, 32'h00000215);
		fast = 1'b1;
		cal_case((32'h1 << CTL_OSCMODE) | (32'h7 << CTL_CALCLK), 8'h9b, 16384, 1'b1);
		fast = 1'b0;
		wr(OFS_MANUAL, 32'h00000111);
		chk(32'({vco_select_o, cap_trim_o}), 32'h9b);
		wr(OFS_CTRL, 32'h1 << CTL_BYPASS);
		wr(OFS_CMD, 32'h1);
		chk(32'({cal_mode_o, vco_select_o, cap_trim_o}), 32'h051);
		// test mode: two feedback ticks per calibration period, overflow still sticky
		wr(OFS_CTRL, (32'h1 << CTL_TEST) | (32'h1 << CTL_CNTSEL));
		repeat (40) @(posedge clk_sys_i);
		rd(OFS_READBACK);
		chk(rd_v, 32'h80005000);
		chk(32'({vco_force_o, vco_force_low_o}), 3);
		close_out();
	end
endmodule
bind pdc_top pdc_chk u_chk (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rdata_o, .pfd_tick_i,
	.feedback_integer_value_o, .prescaler_ratio_select_o, .main_count_o, .swallow_count_o, .vco_select_o,
	.cap_trim_o, .cal_mode_o, .ext_buffer_power_o, .int_vco_power_o, .loop_active_o, .rf_out_enable_o,
	.lo_out_enable_o);
